// File: src/mrf_pkg.sv
package mrf_pkg;

  // Register offsets on the byte-wide register port.
  localparam logic [7:0] TEMP_LOW_ADDR   = 8'h1B;
  localparam logic [7:0] TEMP_HIGH_ADDR  = 8'h1A;
  localparam logic [7:0] DIODE_HIGH_ADDR = 8'h0E;
  localparam logic [7:0] DIODE_LOW_ADDR  = 8'h0F;
  localparam logic [7:0] PWM_UPPER_ADDR  = 8'h09;
  localparam logic [7:0] PWM_CTRL_ADDR   = 8'h08;

  // Field positions and widths.
  localparam int VALID_BIT     = 7;
  localparam int PWM_LSB_BIT   = 7;
  localparam int HIGH_DATA_W   = 5;
  localparam int RESULT_W      = 13;

  // Reset values.
  localparam logic [7:0]  PWM_UPPER_RST = 8'h00;
  localparam logic [7:0]  PWM_CTRL_RST  = 8'h00;
  localparam logic [12:0] RESULT_RST    = 13'h0000;

  // Result register pair and its flag.
  typedef struct packed {
    logic        valid;
    logic [12:0] data;
  } mrf_result_t;

  // Register port request.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mrf_req_t;

endpackage : mrf_pkg

// File: src/mrf_formatter.sv
// Functional notes
// RQ1: A fresh result written into a result register sets its data-valid flag in bit 7.
// RQ2: Addressing a result high register for a read clears its data-valid flag.
// RQ3: The diode high register holds the flag in bit 7, zeros in bits 6:5, result 12:8 in 4:0.
// RQ4: The temperature low register holds result bits 7:0 in bits 7:0.
// RQ5: The diode low register holds result bits 7:0 in bits 7:0.
// RQ6: The threshold register holds threshold bits 8:1, bit 0 lives in the control register.
// RQ7: Single-ended voltages are sign plus 14-bit two's complement at 305.18 uV a step.
// RQ8: Differential voltages use the same coding at 19.075 uV a step.
// RQ9: The supply result is an offset from 2.5 V at 305.18 uV a step.
// RQ10: Temperatures are 13 bits at 0.0625 degree, Celsius signed and Kelvin unsigned.
// RQ11: Raw diode voltage is a positive 13-bit value at 38.15 uV a step.
// RQ12: The temperature high register holds the flag in bit 7, two zeros, result 12:8 in 4:0.
// RQ13: Bit 7 of the control register holds the threshold bit 0 and resets to zero.
// RQ14: Unused bits of the result high registers read as zero and ignore writes.
module mrf_formatter (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_N,
  input  wire mrf_pkg::mrf_req_t     REQ,
  input  wire logic                  TEMP_LOAD,
  input  wire logic [12:0]           TEMP_RESULT,
  input  wire logic                  DIODE_LOAD,
  input  wire logic [12:0]           DIODE_RESULT,
  output logic      [7:0]            RDATA,
  output logic      [8:0]            PWM_THRESHOLD,
  output logic      [7:0]            PWM_CTRL
);

  ////////////////////////////////////////////////////////////////////////////////
  // Result storage. The converter delivers codes already in their final
  // formats, so this block only stores and splits them. Formats pass through
  // bit for bit, which keeps any coding change confined to the front end.

  mrf_pkg::mrf_result_t temp_reg;
  mrf_pkg::mrf_result_t diode_reg;
  mrf_pkg::mrf_result_t next_temp_reg;
  mrf_pkg::mrf_result_t next_diode_reg;
  logic [7:0]           pwm_upper;
  logic [7:0]           pwm_ctrl;
  logic [7:0]           next_pwm_upper;
  logic [7:0]           next_pwm_ctrl;
  logic [7:0]           next_rdata;

  function automatic logic [7:0] high_byte(input mrf_pkg::mrf_result_t r);
    high_byte = {r.valid, 2'h0, r.data[12:8]}; // RQ3 RQ12 RQ14
  endfunction : high_byte

  function automatic mrf_pkg::mrf_result_t update(input mrf_pkg::mrf_result_t r,
                                                  input logic load,
                                                  input logic [12:0] res,
                                                  input logic rd_high);
    update = r;
    // A load in the same cycle as the clearing read wins, so no result is lost.
    if (rd_high) begin
      update.valid = 1'b0; // RQ2
    end
    if (load) begin
      update.data  = res; // RQ7 RQ8 RQ9 RQ10 RQ11
      update.valid = 1'b1; // RQ1
    end
  endfunction : update

  always_comb begin
    next_temp_reg  = update(temp_reg, TEMP_LOAD, TEMP_RESULT,
                            REQ.rd && REQ.addr == mrf_pkg::TEMP_HIGH_ADDR);
    next_diode_reg = update(diode_reg, DIODE_LOAD, DIODE_RESULT,
                            REQ.rd && REQ.addr == mrf_pkg::DIODE_HIGH_ADDR);
    next_pwm_upper = pwm_upper;
    next_pwm_ctrl  = pwm_ctrl;
    if (REQ.wr && REQ.addr == mrf_pkg::PWM_UPPER_ADDR) begin
      next_pwm_upper = REQ.wdata; // RQ6
    end
    if (REQ.wr && REQ.addr == mrf_pkg::PWM_CTRL_ADDR) begin
      next_pwm_ctrl = REQ.wdata; // RQ13
    end
    next_rdata = 8'h00;
    if (REQ.rd) begin
      unique case (REQ.addr)
        mrf_pkg::TEMP_HIGH_ADDR:  next_rdata = high_byte(temp_reg);
        mrf_pkg::TEMP_LOW_ADDR:   next_rdata = temp_reg.data[7:0]; // RQ4
        mrf_pkg::DIODE_HIGH_ADDR: next_rdata = high_byte(diode_reg);
        mrf_pkg::DIODE_LOW_ADDR:  next_rdata = diode_reg.data[7:0]; // RQ5
        mrf_pkg::PWM_UPPER_ADDR:  next_rdata = pwm_upper;
        mrf_pkg::PWM_CTRL_ADDR:   next_rdata = pwm_ctrl;
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      temp_reg  <= '{valid: 1'b0, data: mrf_pkg::RESULT_RST};
      diode_reg <= '{valid: 1'b0, data: mrf_pkg::RESULT_RST};
      pwm_upper <= mrf_pkg::PWM_UPPER_RST;
      pwm_ctrl  <= mrf_pkg::PWM_CTRL_RST; // RQ13
      RDATA     <= 8'h00;
    end else begin
      temp_reg  <= next_temp_reg;
      diode_reg <= next_diode_reg;
      pwm_upper <= next_pwm_upper;
      pwm_ctrl  <= next_pwm_ctrl;
      RDATA     <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The full threshold joins the upper byte with the control register's top bit.

  assign PWM_THRESHOLD = {pwm_upper, pwm_ctrl[mrf_pkg::PWM_LSB_BIT]}; // RQ6 RQ13
  assign PWM_CTRL      = pwm_ctrl;

  ////////////////////////////////////////////////////////////////////////////////

  load_sets_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ1
    TEMP_LOAD |=> temp_reg.valid && temp_reg.data == $past(TEMP_RESULT))
    else $error("Temperature load did not set valid.");
  diode_sets_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ11
    DIODE_LOAD |=> diode_reg.valid && diode_reg.data == $past(DIODE_RESULT))
    else $error("Diode load did not set valid.");
  read_clears_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ2
    REQ.rd && REQ.addr == mrf_pkg::TEMP_HIGH_ADDR && !TEMP_LOAD |=> !temp_reg.valid)
    else $error("Read of temperature high did not clear valid.");
  diode_clears_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ2
    REQ.rd && REQ.addr == mrf_pkg::DIODE_HIGH_ADDR && !DIODE_LOAD |=> !diode_reg.valid)
    else $error("Read of diode high did not clear valid.");
  diode_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ3
    REQ.rd && REQ.addr == mrf_pkg::DIODE_HIGH_ADDR |=>
      RDATA == {$past(diode_reg.valid), 2'h0, $past(diode_reg.data[12:8])})
    else $error("Diode high byte layout wrong.");
  temp_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ12
    REQ.rd && REQ.addr == mrf_pkg::TEMP_HIGH_ADDR |=> RDATA[6:5] == 2'h0)
    else $error("Temperature high unused bits not zero.");
  temp_low_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ4
    REQ.rd && REQ.addr == mrf_pkg::TEMP_LOW_ADDR |=> RDATA == $past(temp_reg.data[7:0]))
    else $error("Temperature low byte wrong.");
  diode_low_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ5
    REQ.rd && REQ.addr == mrf_pkg::DIODE_LOW_ADDR |=> RDATA == $past(diode_reg.data[7:0]))
    else $error("Diode low byte wrong.");
  pwm_join_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ6
    REQ.wr && REQ.addr == mrf_pkg::PWM_UPPER_ADDR |=> PWM_THRESHOLD[8:1] == $past(REQ.wdata))
    else $error("Threshold upper bits not stored.");
  pwm_lsb_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RQ13
    REQ.wr && REQ.addr == mrf_pkg::PWM_CTRL_ADDR |=> PWM_THRESHOLD[0] == $past(REQ.wdata[7]))
    else $error("Threshold bit 0 not from control.");

endmodule : mrf_formatter

// File: bench/mrf_host.sv
module mrf_host (
  input  wire logic             clk,
  output mrf_pkg::mrf_req_t     req,
  input  wire logic [7:0]       rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // Requests change after a falling edge, so the rising edge that takes them sees them settled.
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] d);
    @(negedge clk);
    req = '{rd: rd, wr: !rd, addr: a, wdata: wd};
    @(negedge clk);
    d = rdata;
    req = '0;
  endtask : access

  // The threshold is split, so both bytes must be written before it is whole.
  task automatic set_threshold(input logic [8:0] t, input logic [6:0] ctrl);
    logic [7:0] d;
    access(1'b0, mrf_pkg::PWM_UPPER_ADDR, t[8:1], d);
    access(1'b0, mrf_pkg::PWM_CTRL_ADDR, {t[0], ctrl}, d);
  endtask : set_threshold
endmodule : mrf_host

// File: bench/mrf_formatter_bench.sv
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, e); end end

module mrf_formatter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk;
  logic              rst_n;
  logic              temp_load;
  logic              diode_load;
  logic [12:0]       temp_result;
  logic [12:0]       diode_result;
  logic [7:0]        rdata;
  logic [7:0]        pwm_ctrl;
  logic [7:0]        d;
  logic [8:0]        pwm_threshold;
  mrf_pkg::mrf_req_t req;
  int                num_errors = 0;
  int                total_checks = 0;
  logic [13:0]       vec [4] = '{{1'b0, 13'h1D80}, {1'b0, 13'h18E2}, {1'b1, 13'h1332},
                                 {1'b1, 13'h1FFF}};

  mrf_formatter mrf_formatter_i (.REF_CLK(ref_clk), .RST_N(rst_n), .REQ(req),
    .TEMP_LOAD(temp_load), .TEMP_RESULT(temp_result), .DIODE_LOAD(diode_load),
    .DIODE_RESULT(diode_result), .RDATA(rdata), .PWM_THRESHOLD(pwm_threshold),
    .PWM_CTRL(pwm_ctrl));
  mrf_host mrf_host_i (.clk(ref_clk), .req(req), .rdata(rdata));

  task automatic check_pair(input logic dio, input logic [12:0] v);
    logic [7:0] hi;
    hi = dio ? mrf_pkg::DIODE_HIGH_ADDR : mrf_pkg::TEMP_HIGH_ADDR;
    @(negedge ref_clk);
    temp_load = !dio;
    diode_load = dio;
    temp_result = v;
    diode_result = v;
    @(negedge ref_clk);
    temp_load = 1'b0;
    diode_load = 1'b0;
    // A write to a result register must not disturb it.
    mrf_host_i.access(1'b0, hi, 8'hFF, d);
    mrf_host_i.access(1'b1, hi, 8'h00, d);
    `CHK(d, {1'b1, 2'b00, v[12:8]})
    mrf_host_i.access(1'b1, hi + 8'h01, 8'h00, d);
    `CHK(d, v[7:0])
    mrf_host_i.access(1'b1, hi, 8'h00, d);
    `CHK(d, {3'b000, v[12:8]})
  endtask : check_pair

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #200us;
    num_errors++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    temp_load = 1'b0;
    diode_load = 1'b0;
    temp_result = 13'h0000;
    diode_result = 13'h0000;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK(pwm_threshold, 9'h000)
    mrf_host_i.access(1'b1, 8'h55, 8'h00, d);
    `CHK(d, 8'h00)
    $display("test reset done");
    foreach (vec[i]) check_pair(vec[i][13], vec[i][12:0]);
    $display("test results done");
    mrf_host_i.set_threshold(9'h14B, 7'h00);
    `CHK(pwm_threshold, 9'h14B)
    `CHK(pwm_ctrl, 8'h80)
    mrf_host_i.set_threshold(9'h0FE, 7'h30);
    `CHK(pwm_threshold, 9'h0FE)
    `CHK(pwm_ctrl, 8'h30)
    $display("test threshold done");
    test_done();
  end
endmodule : mrf_formatter_bench
